// [verilog/mem_guard_pkg.sv]
// constants for the core memory parity and protect guard
package mem_guard_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PROT_SW_OFF = 8'h04;
  localparam logic [7:0] PROT_ERR_OFF = 8'h08;
  localparam logic [7:0] PAR_STAT_OFF = 8'h0C;
  localparam logic [7:0] PIN_STAT_OFF = 8'h10;
  // field positions
  localparam int CTRL_PAR_EN_BIT = 0;
  localparam int PAR_ERR_BIT = 0;
  localparam int PAR_BUSY_BIT = 1;
  localparam int PAR_ADDR_LSB = 16;
  // reset values
  localparam logic CTRL_PAR_EN_RST = 1'h1;
  localparam logic [15:0] PROT_SW_RST = 16'h0000;
  // address map: 4K banks, 16 of them, low executive area
  localparam int BANK_BITS = 4;
  localparam int BANK_LSB = 12;
  localparam logic [15:0] EXEC_WORDS = 16'h0100;
  // core cycle phase lengths in clocks
  localparam int READ_CYC = 8;
  localparam int WRITE_CYC = 8;
  // memory cycle owner
  typedef enum logic {OWN_CPU, OWN_DMA} owner_t;
endpackage

// [verilog/mem_guard.sv]
// core memory parity, bank protect and second-controller cycle steal
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module mem_guard #(
  parameter int RD_CYC = mem_guard_pkg::READ_CYC,
  parameter int WR_CYC = mem_guard_pkg::WRITE_CYC,
  parameter int NBANK = 16
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic CPU_REQ_I,
  input wire logic CPU_WR_I,
  input wire logic CPU_FETCH_I,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic [15:0] CPU_WDATA_I,
  output logic [15:0] CPU_RDATA_O,
  output logic CPU_DONE_O,
  output logic CPU_HALT_O,
  input wire logic DMA_REQ_I,
  input wire logic DMA_WR_I,
  input wire logic [15:0] DMA_ADDR_I,
  input wire logic [15:0] DMA_WDATA_I,
  output logic [15:0] DMA_RDATA_O,
  output logic DMA_DONE_O,
  output logic MEM_RD_O,
  output logic MEM_WE_O,
  output logic [15:0] MEM_ADDR_O,
  output logic [17:0] MEM_WDATA_O,
  input wire logic [17:0] MEM_RDATA_I,
  input wire logic [NBANK-1:0] PROTECT_I,
  output logic [NBANK-1:0] PROT_ERR_O,
  output logic PARITY_ERR_O,
  output logic FETCH_PAR_ERR_O
);
  localparam int MAX_CYC = 24;
  typedef enum logic [1:0] {IDLE, READ, WRITE} state_t;

  state_t state;
  mem_guard_pkg::owner_t owner;
  logic [7:0] cnt;
  logic wr;
  logic fetch;
  logic [15:0] wdata;
  logic [17:0] stored;
  logic par_en;
  logic [NBANK-1:0] prot_sw;
  logic [NBANK-1:0] prot_s1;
  logic [NBANK-1:0] prot_s2;
  logic [15:0] fault_addr;
  logic blocked;
  logic par_bad;
  logic read_end;
  logic write_end;
  localparam int BANK_W = mem_guard_pkg::BANK_BITS;
  logic [BANK_W-1:0] bank;
  logic apb_wr;

  // odd parity bit for a byte: byte plus bit holds an odd count of ones
  function automatic logic odd_bit(input logic [7:0] b);
    odd_bit = ~^b;
  endfunction

  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign read_end = (state == READ) && (cnt == 8'(RD_CYC - 1));
  assign write_end = (state == WRITE) && (cnt == 8'(WR_CYC - 1));
  // bank is the top address nibble; dma and cpu share one map
  assign bank = MEM_ADDR_O[15:mem_guard_pkg::BANK_LSB];

  // pin and program protect merged; exec area of bank 0 exempt
  always_comb
  begin
    blocked = wr && (prot_s2[bank] || prot_sw[bank]);
    if (bank == '0 && MEM_ADDR_O < mem_guard_pkg::EXEC_WORDS)
    begin
      blocked = 1'b0;
    end
  end

  // both byte parities checked against the sensed word
  assign par_bad = par_en && !(^MEM_RDATA_I[16] ^ ^MEM_RDATA_I[7:0]
                    && ^MEM_RDATA_I[17] ^ ^MEM_RDATA_I[15:8]);

  // protect pins are switches or another box: two-stage synchroniser
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      prot_s1 <= '0;
      prot_s2 <= '0;
    end
    else
    begin
      prot_s1 <= PROTECT_I;
      prot_s2 <= prot_s1;
    end
  end

  // cycle sequencer: read half senses, write half restores or replaces
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      state <= IDLE;
      owner <= mem_guard_pkg::OWN_CPU;
      cnt <= 8'h00;
      wr <= 1'b0;
      fetch <= 1'b0;
      wdata <= 16'h0000;
      stored <= 18'h00000;
      MEM_RD_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_ADDR_O <= 16'h0000;
      MEM_WDATA_O <= 18'h00000;
    end
    else
    begin
      unique case (state)
        IDLE:
        begin
          cnt <= 8'h00;
          // dma wins a tie; the processor is stalled for the whole dma memory cycle
          if (DMA_REQ_I)
          begin
            owner <= mem_guard_pkg::OWN_DMA;
            wr <= DMA_WR_I;
            fetch <= 1'b0;
            wdata <= DMA_WDATA_I;
            MEM_ADDR_O <= DMA_ADDR_I;
            MEM_RD_O <= 1'b1;
            state <= READ;
          end
          else if (CPU_REQ_I)
          begin
            owner <= mem_guard_pkg::OWN_CPU;
            wr <= CPU_WR_I;
            fetch <= CPU_FETCH_I;
            wdata <= CPU_WDATA_I;
            MEM_ADDR_O <= CPU_ADDR_I;
            MEM_RD_O <= 1'b1;
            state <= READ;
          end
        end
        READ:
        begin
          cnt <= cnt + 8'h01;
          if (read_end)
          begin
            cnt <= 8'h00;
            stored <= MEM_RDATA_I;
            MEM_RD_O <= 1'b0;
            MEM_WE_O <= 1'b1;
            if (wr && !blocked)
            begin
              MEM_WDATA_O <= {odd_bit(wdata[15:8]), odd_bit(wdata[7:0]),
                              wdata};
            end
            else
            begin
              MEM_WDATA_O <= MEM_RDATA_I;
            end
            state <= WRITE;
          end
        end
        WRITE:
        begin
          cnt <= cnt + 8'h01;
          if (write_end)
          begin
            cnt <= 8'h00;
            MEM_WE_O <= 1'b0;
            state <= IDLE;
          end
        end
        default:
        begin
          state <= IDLE;
        end
      endcase
    end
  end

  // completion strobes and read data back to the requester
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      CPU_DONE_O <= 1'b0;
      DMA_DONE_O <= 1'b0;
      CPU_RDATA_O <= 16'h0000;
      DMA_RDATA_O <= 16'h0000;
      CPU_HALT_O <= 1'b0;
    end
    else
    begin
      CPU_DONE_O <= write_end && owner == mem_guard_pkg::OWN_CPU;
      DMA_DONE_O <= write_end && owner == mem_guard_pkg::OWN_DMA;
      if (write_end && owner == mem_guard_pkg::OWN_CPU)
      begin
        CPU_RDATA_O <= stored[15:0];
      end
      if (write_end && owner == mem_guard_pkg::OWN_DMA)
      begin
        DMA_RDATA_O <= stored[15:0];
      end
      // halt from dma accept until its cycle ends
      if (state == IDLE && DMA_REQ_I)
      begin
        CPU_HALT_O <= 1'b1;
      end
      else if (write_end)
      begin
        CPU_HALT_O <= 1'b0;
      end
    end
  end

  // sticky protect and parity flags, fetch flag loaded at each parity event; a new event beats a clear in the same cycle
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      PROT_ERR_O <= '0;
      PARITY_ERR_O <= 1'b0;
      FETCH_PAR_ERR_O <= 1'b0;
      fault_addr <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < NBANK; i++)
      begin
        if (read_end && blocked && bank == BANK_W'(i))
        begin
          PROT_ERR_O[i] <= 1'b1;
        end
        else if (apb_wr && PADDR_I == mem_guard_pkg::PROT_ERR_OFF
                 && PWDATA_I[i])
        begin
          PROT_ERR_O[i] <= 1'b0;
        end
      end
      if (read_end && par_bad)
      begin
        PARITY_ERR_O <= 1'b1;
        FETCH_PAR_ERR_O <= fetch;
        fault_addr <= MEM_ADDR_O;
      end
      else if (apb_wr && PADDR_I == mem_guard_pkg::PAR_STAT_OFF
               && PWDATA_I[mem_guard_pkg::PAR_ERR_BIT])
      begin
        PARITY_ERR_O <= 1'b0;
        FETCH_PAR_ERR_O <= 1'b0;
      end
    end
  end

  // program-owned control registers
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      par_en <= mem_guard_pkg::CTRL_PAR_EN_RST;
      prot_sw <= NBANK'(mem_guard_pkg::PROT_SW_RST);
    end
    else if (apb_wr)
    begin
      if (PADDR_I == mem_guard_pkg::CTRL_OFF)
      begin
        par_en <= PWDATA_I[mem_guard_pkg::CTRL_PAR_EN_BIT];
      end
      if (PADDR_I == mem_guard_pkg::PROT_SW_OFF)
      begin
        prot_sw <= PWDATA_I[NBANK-1:0];
      end
    end
  end

  // apb slave: zero wait states, unmapped offsets answer pslverr
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      if (PSEL_I && !PENABLE_I)
      begin
        unique case (PADDR_I)
          mem_guard_pkg::CTRL_OFF: PRDATA_O <= {31'h0, par_en};
          mem_guard_pkg::PROT_SW_OFF: PRDATA_O <= {16'h0, prot_sw};
          mem_guard_pkg::PROT_ERR_OFF: PRDATA_O <= {16'h0, PROT_ERR_O};
          mem_guard_pkg::PAR_STAT_OFF:
            PRDATA_O <= {fault_addr, 13'h0, FETCH_PAR_ERR_O,
                         state != IDLE, PARITY_ERR_O};
          mem_guard_pkg::PIN_STAT_OFF: PRDATA_O <= {16'h0, prot_s2};
          default: PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end

  // checks
  parity_gen_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(MEM_WE_O) && wr && !$past(blocked) |->
      ^{MEM_WDATA_O[16], MEM_WDATA_O[7:0]}
      && ^{MEM_WDATA_O[17], MEM_WDATA_O[15:8]})
    else $error("written word lacks odd byte parity");
  parity_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    read_end && par_bad |=> PARITY_ERR_O && fault_addr == $past(MEM_ADDR_O))
    else $error("parity fault not flagged");
  fetch_data_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    CPU_DONE_O |-> CPU_RDATA_O == stored[15:0])
    else $error("fetched word not delivered");
  regen_word_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(MEM_WE_O) && $past(blocked) |-> MEM_WDATA_O == stored)
    else $error("blocked write altered memory");
  exec_area_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    state == READ && MEM_ADDR_O < mem_guard_pkg::EXEC_WORDS |-> !blocked)
    else $error("executive area was protected");
  bank_error_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    read_end && blocked |=> PROT_ERR_O[$past(bank)])
    else $error("protect error not set for bank");
  dma_halt_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    state != IDLE && owner == mem_guard_pkg::OWN_DMA |-> CPU_HALT_O)
    else $error("processor not halted during dma");
  dma_cycle_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    state == IDLE && DMA_REQ_I |-> ##[1:MAX_CYC] DMA_DONE_O)
    else $error("dma cycle not completed in time");
  err_sticky_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    PROT_ERR_O[0] && !apb_wr |=> PROT_ERR_O[0])
    else $error("protect error dropped without clear");
endmodule

// [tb/core_stack_model.sv]
// core memory stack model: 18-bit words behind the guard
`timescale 1ns/100ps
module core_stack_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [17:0] wdata_i,
  output logic [17:0] rdata_o
);
  logic [17:0] cells [0:65535];
  logic [17:0] last = 18'h3FFFF;
  // every word starts as zero data with good odd parity
  initial
  begin
    foreach (cells[i])
      cells[i] = 18'h30000;
  end
  // sense lines float to the inverse of the last word outside a read
  always_comb
  begin
    rdata_o = rd_i ? cells[addr_i] : ~last;
  end
  // plain always: the bench pokes bad parity into cells directly
  always @(posedge clk_i)
  begin
    if (we_i)
      cells[addr_i] <= wdata_i;
    if (rd_i)
      last <= cells[addr_i];
  end
endmodule

// [tb/core_memory_parity_protect_tb.sv]
// self-checking bench for the memory parity and protect guard
`timescale 1ns/100ps
module core_memory_parity_protect_tb;
  localparam int RC = 2;
  localparam int WC = 2;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cdone, halt, ddone, mrd, mwe, parerr, fperr;
  logic creq = 1'h0, cwr = 1'h0, cfetch = 1'h0, dreq = 1'h0, dwr = 1'h0;
  logic [15:0] caddr = 16'h0, cwdata = 16'h0, daddr = 16'h0;
  logic [15:0] dwdata = 16'h0, crdata, drdata, maddr, perr, w, a, v;
  logic [15:0] prot = 16'h0;
  logic [17:0] mwdata, mrdata;
  int fails = 0;
  int num_checks = 0;

  mem_guard #(.RD_CYC(RC), .WR_CYC(WC), .NBANK(16)) mem_guard_inst (
    .CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .CPU_REQ_I(creq), .CPU_WR_I(cwr), .CPU_FETCH_I(cfetch),
    .CPU_ADDR_I(caddr), .CPU_WDATA_I(cwdata), .CPU_RDATA_O(crdata),
    .CPU_DONE_O(cdone), .CPU_HALT_O(halt), .DMA_REQ_I(dreq),
    .DMA_WR_I(dwr), .DMA_ADDR_I(daddr), .DMA_WDATA_I(dwdata),
    .DMA_RDATA_O(drdata), .DMA_DONE_O(ddone), .MEM_RD_O(mrd),
    .MEM_WE_O(mwe), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata),
    .MEM_RDATA_I(mrdata), .PROTECT_I(prot), .PROT_ERR_O(perr),
    .PARITY_ERR_O(parerr), .FETCH_PAR_ERR_O(fperr));

  core_stack_model stk (.clk_i(clk), .rd_i(mrd), .we_i(mwe),
    .addr_i(maddr), .wdata_i(mwdata), .rdata_o(mrdata));

  // free-running 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // odd parity per byte, worked out independently of the design
  function automatic logic [17:0] enc(input logic [15:0] d);
    return {~^d[15:8], ~^d[7:0], d};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic results;
  begin
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
  begin
    psel <= 1'h1;
    pwr <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    // one idle edge so a following setup never reassigns psel at once
    @(posedge clk);
  end
  endtask

  // one memory cycle; req dropped at the edge that raises done
  task automatic mcyc(input logic dma, input logic wr, input logic f,
                      input logic [15:0] ad, input logic [15:0] d);
  begin
    dreq <= dma;
    creq <= !dma;
    dwr <= wr;
    cwr <= wr;
    cfetch <= f;
    daddr <= ad;
    caddr <= ad;
    dwdata <= d;
    cwdata <= d;
    do
      @(negedge clk);
    while (mrd !== 1'h1);
    check(halt, dma);
    repeat (RC + WC) @(posedge clk);
    dreq <= 1'h0;
    creq <= 1'h0;
    @(negedge clk);
    check(dma ? ddone : cdone, 1'h1);
    check(halt, 1'h0);
    w = dma ? drdata : crdata;
    @(posedge clk);
  end
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #(40 * 5000);
    fails++;
    results;
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check({parerr, fperr, perr, halt}, 32'h0);
    apb(1'h0, mem_guard_pkg::CTRL_OFF, 32'h0);
    check(rd, 32'h1);
    apb(1'h0, 8'h14, 32'h0);
    check(se, 32'h1);
    check(rd, 32'h0);
    // every bank written by dma, read back by the cpu on even banks and by dma on odd banks
    for (int b = 0; b < 16; b++)
    begin
      a = {b[3:0], 12'h300};
      v = {b[3:0], 12'hA5C} ^ 16'h0F0F;
      mcyc(1'h1, 1'h1, 1'h0, a, v);
      check(stk.cells[a], enc(v));
      mcyc(b[0], 1'h0, 1'h0, a, 16'h0);
      check(w, v);
    end
    check(parerr, 1'h0);
    // corrupt the low byte parity of a bank 5 word, then fetch it
    stk.cells[16'h5300] = stk.cells[16'h5300] ^ 18'h10000;
    mcyc(1'h0, 1'h0, 1'h1, 16'h5300, 16'h0);
    check(w, 16'h5553);
    check({parerr, fperr}, 2'h3);
    apb(1'h0, mem_guard_pkg::PAR_STAT_OFF, 32'h0);
    check(rd & 32'hFFFF0005, 32'h53000005);
    apb(1'h1, mem_guard_pkg::PAR_STAT_OFF, 32'h1);
    apb(1'h0, mem_guard_pkg::PAR_STAT_OFF, 32'h0);
    check({parerr, fperr, rd[2:0]}, 5'h0);
    apb(1'h1, mem_guard_pkg::CTRL_OFF, 32'h0);
    mcyc(1'h1, 1'h0, 1'h0, 16'h5300, 16'h0);
    check(parerr, 1'h0);
    apb(1'h1, mem_guard_pkg::CTRL_OFF, 32'h1);
    // pin protect on banks 3 and 0
    prot <= 16'h0009;
    repeat (3) @(posedge clk);
    mcyc(1'h0, 1'h1, 1'h0, 16'h3300, 16'hFFFF);
    check(stk.cells[16'h3300], enc(16'h3553));
    check(perr, 16'h0008);
    mcyc(1'h0, 1'h1, 1'h0, 16'h2300, 16'h1111);
    check(stk.cells[16'h2300], enc(16'h1111));
    mcyc(1'h0, 1'h1, 1'h0, 16'h00FF, 16'h2222);
    check(stk.cells[16'h00FF], enc(16'h2222));
    mcyc(1'h1, 1'h1, 1'h0, 16'h0100, 16'h3333);
    check(perr, 16'h0009);
    check(stk.cells[16'h0100], enc(16'h0000));
    apb(1'h0, mem_guard_pkg::PIN_STAT_OFF, 32'h0);
    check(rd, 32'h9);
    apb(1'h0, mem_guard_pkg::PROT_ERR_OFF, 32'h0);
    check(rd, 32'h9);
    apb(1'h1, mem_guard_pkg::PROT_ERR_OFF, 32'h9);
    apb(1'h0, mem_guard_pkg::PROT_ERR_OFF, 32'h0);
    check({perr, rd[15:0]}, 32'h0);
    // program protect on the top bank
    prot <= 16'h0;
    apb(1'h1, mem_guard_pkg::PROT_SW_OFF, 32'h8000);
    mcyc(1'h1, 1'h1, 1'h0, 16'hF300, 16'h4444);
    check(stk.cells[16'hF300], enc(16'hF553));
    check(perr, 16'h8000);
    results;
  end
endmodule
